// *** bench/rcsl_board_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcsl_board_model (
  // Bench command
  input wire logic clear_req,
  // Device pins
  output logic master_clear_pin_n,
  output logic oscillator_input_pin
);
  // Switch pulls the pin low; pull-up otherwise
  assign master_clear_pin_n = ~clear_req;
  // Free-running source; half period chosen so no edge meets a rising mclk edge
  initial begin
    oscillator_input_pin = 1'b0;
    forever #208 oscillator_input_pin = ~oscillator_input_pin;
  end
endmodule
`default_nettype wire

// *** bench/rcsl_reset_ctrl_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcsl_reset_ctrl_tb;
  localparam int STARTUP_DELAY_TIMER = 20;
  localparam logic [3:0] EV_HALT = 4'b1100;
  localparam logic [3:0] EV_WDT = 4'b1001;
  // Status after power-on, then after each event of the table
  localparam logic [39:0] EV_ST = {8'h07, 8'h17, 8'h0f, 8'h0f, 8'h18};
  logic mclk, rst_n, hsel, hwrite, clear_req, watchdog_timeout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready;
  logic hreadyout, hresp, master_clear_pin_n, oscillator_input_pin;
  logic clock_output_pin, clock_output_oe_n, core_reset_n, core_halted, instr_tick, irq;
  logic hlt, wdt;
  int bad_count, checks_done, n, i, co, tk;
  assign hready = hreadyout;

  rcsl_reset_ctrl #(.DRT_CYCLES(STARTUP_DELAY_TIMER), .CNT_W(20), .FSR_ONES(3)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .master_clear_pin_n(master_clear_pin_n), .oscillator_input_pin(oscillator_input_pin),
    .clock_output_pin(clock_output_pin), .clock_output_oe_n(clock_output_oe_n),
    .watchdog_timeout(watchdog_timeout), .core_reset_n(core_reset_n), .core_halted(core_halted),
    .instr_tick(instr_tick), .irq(irq));
  rcsl_board_model u_board (.clear_req(clear_req), .master_clear_pin_n(master_clear_pin_n),
    .oscillator_input_pin(oscillator_input_pin));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reads just after an edge see the values sampled at that edge
  task automatic ahb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= rcsl_pkg::HSIZE_WORD;
    haddr <= {26'h0, idx, 2'b00};
    @(posedge mclk);
    while (hready !== 1'b1) begin
      @(posedge mclk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = hrdata;
  endtask
  // Extra edge so the written register shows on the pins before any check
  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    ahb(1'b1, idx, wd);
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask
  // Waits for entry into reset, then counts edges until release
  task automatic wait_up(output int cnt);
    int k;
    k = 0;
    cnt = 0;
    @(posedge mclk);
    while (core_reset_n === 1'b1 && k < 8) begin
      @(posedge mclk);
      k++;
    end
    while (core_reset_n !== 1'b1 && cnt < 2000) begin
      @(posedge mclk);
      cnt++;
    end
  endtask
  task automatic hold_clear();
    @(posedge mclk);
    clear_req <= 1'b1;
    repeat (40) @(posedge mclk);
    check(core_reset_n, 1'b0);
    clear_req <= 1'b0;
  endtask
  task automatic count_osc(output int c, output int t);
    logic po, pc;
    int seen;
    seen = 0;
    c = 0;
    t = 0;
    po = oscillator_input_pin;
    pc = clock_output_pin;
    while (seen < 32) begin
      @(posedge mclk);
      if (oscillator_input_pin && !po) seen++;
      if (clock_output_pin && !pc) c++;
      if (instr_tick === 1'b1) t++;
      po = oscillator_input_pin;
      pc = clock_output_pin;
    end
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = rcsl_pkg::HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    clear_req = 1'b1;
    watchdog_timeout = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // Pin held low past power-up keeps the core in reset
    repeat (30) @(posedge mclk);
    check(core_reset_n, 1'b0);
    clear_req <= 1'b0;
    wait_up(n);
    check({31'h0, n >= STARTUP_DELAY_TIMER - 1 && n <= STARTUP_DELAY_TIMER + 8}, 32'h1);
    rdchk(rcsl_pkg::IDX_STATUS, 32'h18);
    rdchk(rcsl_pkg::IDX_PCL, 32'hff);
    rdchk(rcsl_pkg::IDX_DIR, 32'hff);
    rdchk(rcsl_pkg::IDX_OPTION, 32'h3f);
    rdchk(rcsl_pkg::IDX_FSR, 32'he0);
    rdchk(rcsl_pkg::IDX_RST_INFO, 32'h02);
    rdchk(4'hf, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("test power_on done");
    wr(rcsl_pkg::IDX_IRQ_MASK, 32'h2);
    // Table: watchdog run, clear run, clear halted, watchdog halted
    for (i = 0; i < 4; i++) begin
      hlt = EV_HALT[i];
      wdt = EV_WDT[i];
      wr(rcsl_pkg::IDX_IRQ_ST, 32'h7);
      check(irq, 1'b0);
      wr(rcsl_pkg::IDX_STATUS, 32'he7);
      rdchk(rcsl_pkg::IDX_STATUS, {24'h0, 3'h7, EV_ST[i*8+3 +: 2], 3'h7});
      wr(rcsl_pkg::IDX_PCL, 32'h12);
      wr(rcsl_pkg::IDX_DIR, 32'h0);
      wr(rcsl_pkg::IDX_OPTION, 32'h0);
      wr(rcsl_pkg::IDX_FSR, 32'h05);
      wr(rcsl_pkg::IDX_ACCUM, 32'h50 + i);
      wr(rcsl_pkg::IDX_PORT_B_PINS, 32'ha0 + i);
      wr(rcsl_pkg::IDX_CTRL, {30'h3, 1'b1, hlt});
      check(core_halted, hlt);
      if (wdt) begin
        @(posedge mclk);
        watchdog_timeout <= 1'b1;
        @(posedge mclk);
        watchdog_timeout <= 1'b0;
      end else begin
        hold_clear();
      end
      wait_up(n);
      check({31'h0, n >= STARTUP_DELAY_TIMER - 1 && n <= STARTUP_DELAY_TIMER + 8}, 32'h1);
      check(core_halted, 1'b0);
      rdchk(rcsl_pkg::IDX_STATUS, {24'h0, EV_ST[i*8+8 +: 8]});
      rdchk(rcsl_pkg::IDX_PCL, 32'hff);
      rdchk(rcsl_pkg::IDX_DIR, 32'hff);
      rdchk(rcsl_pkg::IDX_OPTION, 32'h3f);
      rdchk(rcsl_pkg::IDX_FSR, 32'he5);
      rdchk(rcsl_pkg::IDX_ACCUM, 32'h50 + i);
      rdchk(rcsl_pkg::IDX_PORT_B_PINS, 32'ha0 + i);
      rdchk(rcsl_pkg::IDX_RST_INFO, {28'h0, wdt, ~wdt, 2'b00});
      rdchk(rcsl_pkg::IDX_IRQ_ST, {29'h0, 1'b1, wdt, ~wdt});
      check(irq, wdt);
      wr(rcsl_pkg::IDX_IRQ_ST, 32'h2);
      check(irq, 1'b0);
      rdchk(rcsl_pkg::IDX_IRQ_ST, {29'h0, 1'b1, 1'b0, ~wdt});
      $display("test reset_event %0d done", i);
    end
    // Oscillator output in RC and XT modes
    wr(rcsl_pkg::IDX_CTRL, 32'h6);
    count_osc(co, tk);
    check({31'h0, co >= 7 && co <= 9}, 32'h1);
    check(clock_output_oe_n, 1'b0);
    wr(rcsl_pkg::IDX_CTRL, 32'h2);
    count_osc(co, tk);
    check(co, 32'h0);
    check({31'h0, tk >= 7 && tk <= 9}, 32'h1);
    check(clock_output_oe_n, 1'b1);
    $display("test clock_out done");
    results();
  end

  // Whole run is under two thousand cycles
  initial begin
    #400000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire

// *** verilog/rcsl_pkg.sv ***
package rcsl_pkg;

  // ****************************************
  // Register indexes (byte address is 4x)
  // ****************************************
  localparam logic [3:0] IDX_INDOP = 4'h0;
  localparam logic [3:0] IDX_COUNT = 4'h1;
  localparam logic [3:0] IDX_PCL = 4'h2;
  localparam logic [3:0] IDX_STATUS = 4'h3;
  localparam logic [3:0] IDX_FSR = 4'h4;
  localparam logic [3:0] IDX_PORT_A_PINS = 4'h5;
  localparam logic [3:0] IDX_PORT_B_PINS = 4'h6;
  localparam logic [3:0] IDX_PORT_C_PINS = 4'h7;
  localparam logic [3:0] IDX_ACCUM = 4'h8;
  localparam logic [3:0] IDX_DIR = 4'h9;
  localparam logic [3:0] IDX_OPTION = 4'ha;
  localparam logic [3:0] IDX_CTRL = 4'hb;
  localparam logic [3:0] IDX_IRQ_ST = 4'hc;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hd;
  localparam logic [3:0] IDX_RST_INFO = 4'he;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned ST_TO_BIT = 4;
  localparam int unsigned ST_PD_BIT = 3;
  localparam logic [2:0] ST_PAGE_RST = 3'h0;
  localparam logic [7:0] PCL_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [5:0] OPT_RST = 6'h3f;
  localparam int unsigned FSR_ONES_SMALL = 3;
  localparam int unsigned CTRL_HALT_BIT = 0;
  localparam int unsigned CTRL_OSC_LSB = 1;
  localparam int unsigned IRQ_MASTER_CLEAR_PIN_BIT = 0;
  localparam int unsigned IRQ_WDT_BIT = 1;
  localparam int unsigned IRQ_READY_BIT = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned DRT_TIME_US = 18000;
  localparam int unsigned DRT_CYCLES = DRT_TIME_US * CLK_KHZ / 1000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OSC_LP = 2'h0,
    OSC_XT = 2'h1,
    OSC_HS = 2'h2,
    OSC_RC = 2'h3
  } rcsl_osc_t;
  localparam rcsl_osc_t OSC_RST = OSC_RC;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_HOLD = 3'h2,
    ST_DELAY = 3'h4
  } rcsl_state_t;

  typedef enum logic [2:0] {
    CAUSE_POR = 3'h1,
    CAUSE_MASTER_CLEAR_PIN = 3'h2,
    CAUSE_WDT = 3'h4
  } rcsl_cause_t;

  typedef struct packed {
    logic hit;
    logic wr;
    logic [3:0] idx;
  } rcsl_aph_t;

endpackage

// *** verilog/rcsl_reset_ctrl.sv ***
// Contract
// - Five reset sources: POR, clear, watchdog, run/halt
// - Wake-up from halt is a full reset
// - Undefined registers keep contents except power-on
// - Other registers forced to reset state always
// - Timeout and powerdown flags at status 4:3
// - POR 1/1; clear run keeps; watchdog run 0/1
// - Clear wake 1/0; watchdog wake 0/0
// - Status layout and reset values 0001 1xxx
// - Direction, program counter low, option to ones
// - Pointer top bits read ones after reset
// - RC mode drives clock out at osc/4
// - Crystal modes accept external clock on input
// - Delay timer starts on clear high, 18 ms
// - Watchdog time-out also runs delay timer
`timescale 1ns/1ns
`default_nettype none
module rcsl_reset_ctrl #(
  parameter int unsigned DRT_CYCLES = rcsl_pkg::DRT_CYCLES,
  parameter int unsigned CNT_W = 20,
  parameter int unsigned FSR_ONES = rcsl_pkg::FSR_ONES_SMALL
) (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device pins
  input wire logic master_clear_pin_n,
  input wire logic oscillator_input_pin,
  output logic clock_output_pin,
  output logic clock_output_oe_n,
  // Core side
  input wire logic watchdog_timeout,
  output logic core_reset_n,
  output logic core_halted,
  output logic instr_tick,
  output logic irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire logic [1:0] pin_raw;
  wire logic [1:0] pin_lvl;
  logic master_clear_pin_low;
  logic osc_lvl;

  assign pin_raw = {oscillator_input_pin, master_clear_pin_n};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic [2:0] s_reg;
    logic lvl_reg;
    // Low at reset so the core waits for the clear pin to be seen high
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s_reg <= 3'h0;
        lvl_reg <= 1'b0;
      end else begin
        s_reg <= {s_reg[1:0], pin_raw[i]};
        if (s_reg[1] == s_reg[2]) begin
          lvl_reg <= s_reg[2];
        end
      end
    end
    assign pin_lvl[i] = lvl_reg;
  end

  assign master_clear_pin_low = !pin_lvl[0];
  assign osc_lvl = pin_lvl[1];

  // ****************************************
  // Reset sequencer
  // ****************************************
  rcsl_pkg::rcsl_state_t state_reg;
  rcsl_pkg::rcsl_state_t state_next;
  rcsl_pkg::rcsl_cause_t cause_reg;
  logic [CNT_W-1:0] drt_cnt_reg;
  logic drt_done;
  logic rst_apply;
  logic apply_wdt;
  logic halted_reg;
  logic core_reset_n_reg;

  assign drt_done = drt_cnt_reg == CNT_W'(DRT_CYCLES - 1);
  assign apply_wdt = rst_apply & !master_clear_pin_low;

  always_comb begin
    state_next = state_reg;
    rst_apply = 1'b0;
    unique case (state_reg)
      rcsl_pkg::ST_RUN: begin
        if (master_clear_pin_low) begin
          state_next = rcsl_pkg::ST_HOLD;
          rst_apply = 1'b1;
        end else if (watchdog_timeout) begin
          state_next = rcsl_pkg::ST_DELAY;
          rst_apply = 1'b1;
        end
      end
      rcsl_pkg::ST_HOLD: begin
        if (!master_clear_pin_low) begin
          state_next = rcsl_pkg::ST_DELAY;
        end
      end
      rcsl_pkg::ST_DELAY: begin
        if (master_clear_pin_low) begin
          state_next = rcsl_pkg::ST_HOLD;
        end else if (drt_done) begin
          state_next = rcsl_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = rcsl_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rcsl_pkg::ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counter restarts whenever the sequencer leaves the delay state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drt_cnt_reg <= '0;
    end else if (state_reg == rcsl_pkg::ST_DELAY && !master_clear_pin_low) begin
      drt_cnt_reg <= drt_cnt_reg + CNT_W'(1);
    end else begin
      drt_cnt_reg <= '0;
    end
  end

  // Registered so every core flop leaves reset on one edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_n_reg <= 1'b0;
    end else begin
      core_reset_n_reg <= state_next == rcsl_pkg::ST_RUN;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= rcsl_pkg::CAUSE_POR;
    end else if (rst_apply) begin
      cause_reg <= apply_wdt ? rcsl_pkg::CAUSE_WDT : rcsl_pkg::CAUSE_MASTER_CLEAR_PIN;
    end
  end

  // ****************************************
  // Bus address phase
  // ****************************************
  rcsl_pkg::rcsl_aph_t aph_reg;
  logic aph_take;
  logic aph_hit;
  logic wr_en;
  logic rd_wait_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;

  assign aph_take = hsel & htrans[1] & hready;
  assign aph_hit = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0)
    && (hsize == rcsl_pkg::HSIZE_WORD) && (haddr[5:2] <= rcsl_pkg::IDX_RST_INFO);
  assign wr_en = aph_reg.hit & aph_reg.wr & !rd_wait_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aph_reg <= '0;
    end else if (hready) begin
      aph_reg <= '{hit: aph_take & aph_hit, wr: hwrite, idx: haddr[5:2]};
    end
  end

  // Reads take one wait state so data comes from settled flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_wait_reg <= 1'b0;
      hrdata_reg <= 32'h0;
    end else begin
      rd_wait_reg <= aph_take & !hwrite & !rd_wait_reg;
      if (rd_wait_reg) begin
        hrdata_reg <= aph_reg.hit ? rd_mux : 32'h0;
      end
    end
  end

  assign hreadyout = !rd_wait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ****************************************
  // Core special registers
  // ****************************************
  logic [7:0] pcl_reg;
  logic [7:0] dir_reg;
  logic [5:0] opt_reg;
  logic [2:0] page_reg;
  logic to_reg;
  logic pd_reg;
  logic [2:0] alu_flags_reg;
  logic [7:0] fsr_reg;
  logic [7:0] fsr_mask;
  logic [7:0] count_reg;
  logic [7:0] accum_reg;
  logic [3:0] port_a_pins_reg;
  logic [7:0] port_b_pins_reg;
  logic [7:0] port_c_pins_reg;
  rcsl_pkg::rcsl_osc_t osc_mode_reg;

  assign fsr_mask = 8'(8'hff << (8 - FSR_ONES));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcl_reg <= rcsl_pkg::PCL_RST;
      dir_reg <= rcsl_pkg::DIR_RST;
      opt_reg <= rcsl_pkg::OPT_RST;
    end else if (rst_apply) begin
      pcl_reg <= rcsl_pkg::PCL_RST;
      dir_reg <= rcsl_pkg::DIR_RST;
      opt_reg <= rcsl_pkg::OPT_RST;
    end else if (wr_en) begin
      if (aph_reg.idx == rcsl_pkg::IDX_PCL) pcl_reg <= hwdata[7:0];
      if (aph_reg.idx == rcsl_pkg::IDX_DIR) dir_reg <= hwdata[7:0];
      if (aph_reg.idx == rcsl_pkg::IDX_OPTION) opt_reg <= hwdata[5:0];
    end
  end

  // Flags are read-only to software; only a reset moves them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
    end else if (rst_apply && (apply_wdt || halted_reg)) begin
      to_reg <= !apply_wdt;
      pd_reg <= !halted_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= rcsl_pkg::ST_PAGE_RST;
      alu_flags_reg <= 3'h0;
    end else if (rst_apply) begin
      page_reg <= rcsl_pkg::ST_PAGE_RST;
    end else if (wr_en && aph_reg.idx == rcsl_pkg::IDX_STATUS) begin
      page_reg <= hwdata[7:5];
      alu_flags_reg <= hwdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fsr_reg <= 8'(8'hff << (8 - FSR_ONES));
    end else if (rst_apply) begin
      fsr_reg <= fsr_reg | fsr_mask;
    end else if (wr_en && aph_reg.idx == rcsl_pkg::IDX_FSR) begin
      fsr_reg <= hwdata[7:0];
    end
  end

  // Only power-on loads these (zero, oscillator mode RC); later resets leave them alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 8'h0;
      accum_reg <= 8'h0;
      port_a_pins_reg <= 4'h0;
      port_b_pins_reg <= 8'h0;
      port_c_pins_reg <= 8'h0;
      osc_mode_reg <= rcsl_pkg::OSC_RST;
    end else if (wr_en) begin
      unique case (aph_reg.idx)
        rcsl_pkg::IDX_COUNT: count_reg <= hwdata[7:0];
        rcsl_pkg::IDX_ACCUM: accum_reg <= hwdata[7:0];
        rcsl_pkg::IDX_PORT_A_PINS: port_a_pins_reg <= hwdata[3:0];
        rcsl_pkg::IDX_PORT_B_PINS: port_b_pins_reg <= hwdata[7:0];
        rcsl_pkg::IDX_PORT_C_PINS: port_c_pins_reg <= hwdata[7:0];
        rcsl_pkg::IDX_CTRL: begin
          osc_mode_reg <= rcsl_pkg::rcsl_osc_t'(hwdata[rcsl_pkg::CTRL_OSC_LSB +: 2]);
        end
        default: begin
        end
      endcase
    end
  end

  // Any reset ends halt; a CTRL write with the halt bit clear also ends it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halted_reg <= 1'b0;
    end else if (rst_apply) begin
      halted_reg <= 1'b0;
    end else if (wr_en && aph_reg.idx == rcsl_pkg::IDX_CTRL) begin
      halted_reg <= hwdata[rcsl_pkg::CTRL_HALT_BIT];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [rcsl_pkg::IRQ_W-1:0] irq_st_reg;
  logic [rcsl_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [rcsl_pkg::IRQ_W-1:0] irq_set;
  logic [rcsl_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[rcsl_pkg::IRQ_MASTER_CLEAR_PIN_BIT] = rst_apply & !apply_wdt;
    irq_set[rcsl_pkg::IRQ_WDT_BIT] = apply_wdt;
    irq_set[rcsl_pkg::IRQ_READY_BIT] = state_reg != rcsl_pkg::ST_RUN
      && state_next == rcsl_pkg::ST_RUN;
    irq_clr = '0;
    if (wr_en && aph_reg.idx == rcsl_pkg::IDX_IRQ_ST) begin
      irq_clr = hwdata[rcsl_pkg::IRQ_W-1:0];
    end
  end

  // Set beats a simultaneous write-one-to-clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_reg <= '0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (wr_en && aph_reg.idx == rcsl_pkg::IDX_IRQ_MASK) begin
      irq_mask_reg <= hwdata[rcsl_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_st_reg & irq_mask_reg);

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_mux = 32'h0;
    unique case (aph_reg.idx)
      rcsl_pkg::IDX_COUNT: rd_mux[7:0] = count_reg;
      rcsl_pkg::IDX_PCL: rd_mux[7:0] = pcl_reg;
      rcsl_pkg::IDX_STATUS: rd_mux[7:0] = {page_reg, to_reg, pd_reg, alu_flags_reg};
      rcsl_pkg::IDX_FSR: rd_mux[7:0] = fsr_reg | fsr_mask;
      rcsl_pkg::IDX_PORT_A_PINS: rd_mux[3:0] = port_a_pins_reg;
      rcsl_pkg::IDX_PORT_B_PINS: rd_mux[7:0] = port_b_pins_reg;
      rcsl_pkg::IDX_PORT_C_PINS: rd_mux[7:0] = port_c_pins_reg;
      rcsl_pkg::IDX_ACCUM: rd_mux[7:0] = accum_reg;
      rcsl_pkg::IDX_DIR: rd_mux[7:0] = dir_reg;
      rcsl_pkg::IDX_OPTION: rd_mux[5:0] = opt_reg;
      rcsl_pkg::IDX_CTRL: rd_mux[2:0] = {osc_mode_reg, halted_reg};
      rcsl_pkg::IDX_IRQ_ST: rd_mux[rcsl_pkg::IRQ_W-1:0] = irq_st_reg;
      rcsl_pkg::IDX_IRQ_MASK: rd_mux[rcsl_pkg::IRQ_W-1:0] = irq_mask_reg;
      rcsl_pkg::IDX_RST_INFO: rd_mux[3:0] = {cause_reg, !core_reset_n_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************
  // Oscillator divider
  // ****************************************
  logic osc_prev_reg;
  logic [1:0] div_reg;
  logic osc_rise;
  logic clkout_reg;
  logic clkout_oe_n_reg;
  logic tick_reg;
  logic rc_mode;

  assign osc_rise = osc_lvl & !osc_prev_reg;
  assign rc_mode = osc_mode_reg == rcsl_pkg::OSC_RC;

  // Edge count works for any mode, so an external clock also drives it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev_reg <= 1'b0;
      div_reg <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_lvl;
      tick_reg <= osc_rise && div_reg == 2'h3;
      if (osc_rise) begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end

  // Crystal modes leave the pin to the resonator
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkout_reg <= 1'b0;
      clkout_oe_n_reg <= 1'b0;
    end else begin
      clkout_reg <= rc_mode & div_reg[1];
      clkout_oe_n_reg <= !rc_mode;
    end
  end

  assign clock_output_pin = clkout_reg;
  assign clock_output_oe_n = clkout_oe_n_reg;
  assign instr_tick = tick_reg;
  assign core_reset_n = core_reset_n_reg;
  assign core_halted = halted_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_wdt_delay:
    assert property (state_reg == rcsl_pkg::ST_RUN && !master_clear_pin_low && watchdog_timeout
      |=> state_reg == rcsl_pkg::ST_DELAY && !core_reset_n)
    else $error("watchdog did not start delay");

  chk_clear_hold:
    assert property (master_clear_pin_low |=> state_reg == rcsl_pkg::ST_HOLD ##1 !core_reset_n)
    else $error("clear low did not hold reset");

  chk_delay_release:
    assert property (state_reg == rcsl_pkg::ST_DELAY && drt_done && !master_clear_pin_low
      |=> core_reset_n && state_reg == rcsl_pkg::ST_RUN)
    else $error("delay end did not release reset");

  chk_early_release:
    assert property ($rose(core_reset_n) |-> $past(state_reg) == rcsl_pkg::ST_DELAY && $past(drt_done))
    else $error("reset released before delay end");

  chk_run_flags:
    assert property (rst_apply && !halted_reg |=> to_reg == !$past(apply_wdt) || !$past(apply_wdt)
      ##0 (!$past(apply_wdt) || pd_reg))
    else $error("run reset flags wrong");

  chk_wake_flags:
    assert property (rst_apply && halted_reg |=> !pd_reg && to_reg == !$past(apply_wdt) && !halted_reg)
    else $error("wake reset flags wrong");

  chk_ones_load:
    assert property (rst_apply |=> pcl_reg == 8'hff && dir_reg == 8'hff && opt_reg == 6'h3f)
    else $error("reset did not load ones");

  chk_fsr_top:
    assert property (rst_apply |=> (fsr_reg & fsr_mask) == fsr_mask)
    else $error("pointer top bits not ones");

  chk_clkout_mode:
    assert property (!rc_mode |=> clock_output_oe_n && !clock_output_pin)
    else $error("clock out driven in crystal mode");

endmodule
`default_nettype wire
